/* rtl/rtc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_core (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Oscillator tick (32.768 kHz domain pulse) and supply comparator
   input wire logic i_osc_tick,
   input wire logic i_supply_ok,
   // Host bus
   input wire logic i_cs,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [16:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // Status outputs
   output logic o_irq,
   output logic o_osc_enable,
   output logic o_on_backup,
   output logic o_store_start
);
   import rtc_pkg::*;

   typedef enum logic [2:0] {
      PW_BACKUP = 3'b001,
      PW_CHECK = 3'b010,
      PW_RUN = 3'b100
   } pwr_t;

   // Synchronisers for the pins
   logic tick_s1, tick_s2, tick_d, sup_s1, sup_s2;
   logic osc_pulse;
   always_ff @(posedge i_ref_clk) begin
      tick_s1 <= i_osc_tick;
      tick_s2 <= tick_s1;
      tick_d <= tick_s2;
      sup_s1 <= i_supply_ok;
      sup_s2 <= sup_s1;
   end
   assign osc_pulse = tick_s2 & ~tick_d;

   function automatic logic is_addr(input logic [16:0] a, input logic [16:0] b);
      return a == b;
   endfunction : is_addr

   // State
   pwr_t pwr, next_pwr;
   logic [7:0] flags, next_flags, cal, next_cal, ien, next_ien, wd, next_wd, rdata, next_rdata;
   logic [7:0] alm [0:3];
   logic [7:0] next_alm [0:3];
   logic [7:0] tm [0:3];
   logic [7:0] next_tm [0:3];
   logic [5:0] wd_cnt, next_wd_cnt, min_cyc, next_min_cyc;
   logic [9:0] wd_div, next_wd_div;
   logic [4:0] tst_div, next_tst_div;
   logic [15:0] sec_div, next_sec_div;
   logic [31:0] win, next_win, start_cnt, next_start_cnt;
   logic tst_out, next_tst_out, adj_done, next_adj_done, seen_osc, next_seen_osc;
   logic osc_run, next_osc_run, alm_hit_d, next_alm_hit_d, w_prev, next_w_prev;
   // Shadow memory signals and the two transfer walks
   logic sh_we, restoring, next_restoring, alm_load, next_alm_load;
   logic [2:0] sh_waddr, sh_raddr, rest_idx, next_rest_idx, alm_idx, next_alm_idx;
   logic [7:0] sh_wdata, sh_rdata;

   rtc_regfile u_shadow (
      .i_ref_clk(i_ref_clk),
      .i_we(sh_we),
      .i_waddr(sh_waddr),
      .i_wdata(sh_wdata),
      .i_raddr(sh_raddr),
      .o_rdata(sh_rdata)
   );

   logic host_ok, wr_en, rd_en, w_bit, sec_end, adj_on, wd_tick, alm_hit, wd_fire, osc_fail_set;
   logic [16:0] sec_len;
   logic [4:0] mag;
   assign host_ok = (pwr != PW_BACKUP);
   assign wr_en = i_cs & i_wr & host_ok;
   assign rd_en = i_cs & i_rd & host_ok;
   assign w_bit = flags[FLG_W];
   assign mag = cal[4:0];
   // adjust in the first 2N minutes only
   assign adj_on = (mag != 5'h00) && (min_cyc < {mag, 1'b0}) && !adj_done;
   assign sec_len = adj_on ? (cal[CAL_SIGN] ? 17'(SEC_CNT - CAL_SHORT)
                                           : 17'(SEC_CNT + CAL_LONG))
                           : 17'(SEC_CNT);
   assign sec_end = osc_run && osc_pulse && ({1'b0, sec_div} >= sec_len - 17'h00001);
   assign wd_tick = osc_run && osc_pulse && (wd_div == 10'(WDOG_DIV - 1));
   // Terminal count of an enabled watchdog
   assign wd_fire = (wd[5:0] != 6'h00) && wd_tick && (wd_cnt <= 6'h01);
   // No tick by the end of the window with the oscillator enabled
   assign osc_fail_set = (pwr == PW_CHECK) && sup_s2 && (win >= 32'(FAIL_WIN_CYC - 1)) &&
                         !cal[CAL_OFF] && !seen_osc && !osc_pulse;
   // masked compare, all masks set disables
   always_comb begin
      alm_hit = 1'b0;
      if (!(alm[0][ALM_MASK] & alm[1][ALM_MASK] & alm[2][ALM_MASK] & alm[3][ALM_MASK])) begin
         alm_hit = 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (!alm[i][ALM_MASK] && (alm[i][6:0] != tm[i][6:0])) begin
               alm_hit = 1'b0;
            end
         end
      end
   end

   // Main next-state logic
   always_comb begin
      next_pwr = pwr;
      next_flags = flags;
      next_cal = cal;
      next_ien = ien;
      next_wd = wd;
      next_wd_cnt = wd_cnt;
      next_wd_div = wd_div;
      next_tst_div = tst_div;
      next_tst_out = tst_out;
      next_sec_div = sec_div;
      next_min_cyc = min_cyc;
      next_adj_done = adj_done;
      next_win = win;
      next_seen_osc = seen_osc;
      next_start_cnt = start_cnt;
      next_osc_run = osc_run;
      next_alm_hit_d = alm_hit;
      next_rdata = rdata;
      next_w_prev = w_bit;
      next_rest_idx = rest_idx;
      next_restoring = restoring;
      next_alm_idx = alm_idx;
      next_alm_load = alm_load;
      for (int i = 0; i < 4; i++) begin
         next_alm[i] = alm[i];
         next_tm[i] = tm[i];
      end
      sh_we = 1'b0;
      sh_waddr = 3'h0;
      sh_wdata = ZERO8;
      sh_raddr = restoring ? rest_idx : 3'(SH_ALM + alm_idx);
      // Oscillator start delay after enabling
      if (cal[CAL_OFF]) begin
         next_osc_run = 1'b0;
         next_start_cnt = 32'h0;
      end else if (!osc_run) begin
         if (osc_pulse || start_cnt >= 32'(START_MAX_CYC - 1)) begin
            next_osc_run = 1'b1;
         end else begin
            next_start_cnt = start_cnt + 32'h1;
         end
      end
      // Power monitor
      case (pwr)
         PW_BACKUP: begin
            if (sup_s2) begin
               next_pwr = PW_CHECK;
               next_win = 32'h0;
               next_seen_osc = 1'b0;
            end
         end
         PW_CHECK: begin
            if (osc_pulse) begin
               next_seen_osc = 1'b1;
            end
            if (!sup_s2) begin
               next_pwr = PW_BACKUP;
            end else if (win >= 32'(FAIL_WIN_CYC - 1)) begin
               next_pwr = PW_RUN;
               if (osc_fail_set) begin
                  next_restoring = 1'b1;
                  next_rest_idx = 3'h0;
               end
            end else begin
               next_win = win + 32'h1;
            end
         end
         PW_RUN: begin
            if (!sup_s2) begin
               next_pwr = PW_BACKUP;
            end
         end
         default: next_pwr = PW_BACKUP;
      endcase
      // Seconds divider with calibration
      if (osc_run && osc_pulse) begin
         next_sec_div = sec_end ? 16'h0000 : sec_div + 16'h0001;
      end
      if (sec_end && !w_bit) begin
         next_adj_done = adj_on ? 1'b1 : adj_done;
         next_tm[0] = tm[0] + ONE_BCD;
         if (tm[0] >= SEC_LAST) begin
            next_tm[0] = ZERO8;
            next_tm[1] = tm[1] + ONE_BCD;
            next_adj_done = 1'b0;
            next_min_cyc = 6'(min_cyc + 6'h01);
            if (tm[1] >= SEC_LAST) begin
               next_tm[1] = ZERO8;
               next_tm[2] = tm[2] + ONE_BCD;
               if (tm[2] >= HOUR_LAST) begin
                  next_tm[2] = ZERO8;
                  next_tm[3] = tm[3] + ONE_BCD;
               end
            end
         end
      end
      // Uncalibrated 512 Hz test output
      if (osc_run && osc_pulse) begin
         next_tst_div = 5'(tst_div + 5'h01);
         if (tst_div == 5'(TEST_DIV - 1)) begin
            next_tst_out = ~tst_out;
         end
      end
      // Watchdog
      if (osc_run && osc_pulse) begin
         next_wd_div = 10'(wd_div + 10'h001);
      end
      if (wd[5:0] != 6'h00 && wd_tick) begin
         if (wd_fire) begin
            next_wd_cnt = wd[5:0];
         end else begin
            next_wd_cnt = wd_cnt - 6'h01;
         end
      end
      // Restore base time from shadow after a failure or a write bit fall
      if (restoring) begin
         next_rest_idx = rest_idx + 3'h1;
         if (rest_idx != 3'h0) begin
            next_tm[2'(rest_idx - 3'h1)] = sh_rdata;
         end
         if (rest_idx == 3'h4) begin
            next_restoring = 1'b0;
         end
      end
      // Alarm shadow walk, after the time walk
      if (alm_load && !restoring) begin
         next_alm_idx = alm_idx + 3'h1;
         if (alm_idx != 3'h0) begin
            next_alm[2'(alm_idx - 3'h1)] = sh_rdata;
         end
         if (alm_idx == 3'h4) begin
            next_alm_load = 1'b0;
         end
      end
      // Host reads
      if (rd_en) begin
         if (is_addr(i_addr, ADDR_FLAGS)) begin
            next_rdata = flags;
            next_flags[FLG_WDF] = 1'b0;
            next_flags[FLG_AF] = 1'b0;
         end else if (is_addr(i_addr, ADDR_CAL)) begin
            next_rdata = cal;
         end else if (is_addr(i_addr, ADDR_WDOG)) begin
            next_rdata = {1'b0, wd[6:0]};
         end else if (is_addr(i_addr, ADDR_IRQ_EN)) begin
            next_rdata = ien;
         end else if (i_addr >= ADDR_ALM_SEC && i_addr <= ADDR_ALM_DATE) begin
            next_rdata = alm[2'(i_addr - ADDR_ALM_SEC)];
         end else if (i_addr >= ADDR_SEC && i_addr <= ADDR_DATE) begin
            next_rdata = tm[2'(i_addr - ADDR_SEC)];
         end else begin
            next_rdata = ZERO8;
         end
      end
      // Host writes
      if (wr_en) begin
         if (is_addr(i_addr, ADDR_FLAGS)) begin
            next_flags[FLG_W] = i_wdata[FLG_W];
            if (w_bit) begin
               next_flags[FLG_CAL] = i_wdata[FLG_CAL];
               next_flags[FLG_OSCILLATOR_FAIL_FLAG] = flags[FLG_OSCILLATOR_FAIL_FLAG] & i_wdata[FLG_OSCILLATOR_FAIL_FLAG];
            end
         end else if (is_addr(i_addr, ADDR_CAL)) begin
            next_cal = {i_wdata[7], 1'b0, i_wdata[5:0]};
         end else if (is_addr(i_addr, ADDR_IRQ_EN)) begin
            next_ien = i_wdata;
         end else if (is_addr(i_addr, ADDR_WDOG)) begin
            next_wd[WD_LOCK] = i_wdata[WD_LOCK];
            if (!i_wdata[WD_LOCK]) begin
               next_wd[5:0] = i_wdata[5:0];
            end
            if (i_wdata[WD_KICK]) begin
               next_wd_cnt = i_wdata[WD_LOCK] ? wd[5:0] : i_wdata[5:0];
               next_wd_div = 10'h000;
            end
         end else if (w_bit && i_addr >= ADDR_ALM_SEC && i_addr <= ADDR_ALM_DATE) begin
            sh_we = 1'b1;
            sh_waddr = 3'(SH_ALM + 3'(i_addr - ADDR_ALM_SEC));
            sh_wdata = i_wdata;
         end else if (w_bit && i_addr >= ADDR_SEC && i_addr <= ADDR_DATE) begin
            sh_we = 1'b1;
            sh_waddr = 3'(i_addr - ADDR_SEC);
            sh_wdata = i_wdata;
         end
      end
      // Write bit falling: load time and alarm from shadow
      if (w_prev && !w_bit) begin
         next_restoring = 1'b1;
         next_rest_idx = 3'h0;
         next_alm_load = 1'b1;
         next_alm_idx = 3'h0;
      end
      // Event sets come last so a set wins over a read clear
      if (alm_hit && !alm_hit_d) begin
         next_flags[FLG_AF] = 1'b1;
      end
      if (wd_fire) begin
         next_flags[FLG_WDF] = 1'b1;
      end
      if (osc_fail_set) begin
         next_flags[FLG_OSCILLATOR_FAIL_FLAG] = 1'b1;
      end
   end

   // Register update
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         pwr <= PW_BACKUP;
         flags <= ZERO8;
         cal <= ZERO8;
         ien <= ZERO8;
         wd <= ZERO8;
         wd_cnt <= 6'h00;
         wd_div <= 10'h000;
         tst_div <= 5'h00;
         tst_out <= 1'b0;
         sec_div <= 16'h0000;
         min_cyc <= 6'h00;
         adj_done <= 1'b0;
         win <= 32'h0;
         seen_osc <= 1'b0;
         start_cnt <= 32'h0;
         osc_run <= 1'b0;
         alm_hit_d <= 1'b0;
         rdata <= ZERO8;
         w_prev <= 1'b0;
         rest_idx <= 3'h0;
         restoring <= 1'b0;
         alm_idx <= 3'h0;
         alm_load <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            alm[i] <= 8'hFF;
            tm[i] <= ZERO8;
         end
      end else begin
         pwr <= next_pwr;
         flags <= next_flags;
         cal <= next_cal;
         ien <= next_ien;
         wd <= next_wd;
         wd_cnt <= next_wd_cnt;
         wd_div <= next_wd_div;
         tst_div <= next_tst_div;
         tst_out <= next_tst_out;
         sec_div <= next_sec_div;
         min_cyc <= next_min_cyc;
         adj_done <= next_adj_done;
         win <= next_win;
         seen_osc <= next_seen_osc;
         start_cnt <= next_start_cnt;
         osc_run <= next_osc_run;
         alm_hit_d <= next_alm_hit_d;
         rdata <= next_rdata;
         w_prev <= next_w_prev;
         rest_idx <= next_rest_idx;
         restoring <= next_restoring;
         alm_idx <= next_alm_idx;
         alm_load <= next_alm_load;
         for (int i = 0; i < 4; i++) begin
            tm[i] <= next_tm[i];
            alm[i] <= next_alm[i];
         end
      end
   end

   // Outputs
   assign o_rdata = rdata;
   // irq from flag and enable, or from the test output while the cal flag is set, not on backup
   assign o_irq = host_ok & ((flags[FLG_CAL] & tst_out) |
                             (flags[FLG_AF] & ien[IE_AIE]) |
                             (flags[FLG_WDF] & ien[IE_WIE]));
   assign o_osc_enable = ~cal[CAL_OFF];
   assign o_on_backup = (pwr == PW_BACKUP);
   assign o_store_start = (pwr != PW_BACKUP) & ~sup_s2;
endmodule : rtc_core
`default_nettype wire

/* rtl/rtc_pkg.sv */
package rtc_pkg;
   // Register byte addresses on the parallel bus
   localparam logic [16:0] ADDR_FLAGS = 17'h1FFF0;
   localparam logic [16:0] ADDR_ALM_SEC = 17'h1FFF2;
   localparam logic [16:0] ADDR_ALM_MIN = 17'h1FFF3;
   localparam logic [16:0] ADDR_ALM_HOUR = 17'h1FFF4;
   localparam logic [16:0] ADDR_ALM_DATE = 17'h1FFF5;
   localparam logic [16:0] ADDR_IRQ_EN = 17'h1FFF6;
   localparam logic [16:0] ADDR_WDOG = 17'h1FFF7;
   localparam logic [16:0] ADDR_CAL = 17'h1FFF8;
   localparam logic [16:0] ADDR_SEC = 17'h1FFF9;
   localparam logic [16:0] ADDR_MIN = 17'h1FFFA;
   localparam logic [16:0] ADDR_HOUR = 17'h1FFFB;
   localparam logic [16:0] ADDR_DATE = 17'h1FFFC;
   // Flag register fields
   localparam int FLG_WDF = 7;
   localparam int FLG_AF = 6;
   localparam int FLG_OSCILLATOR_FAIL_FLAG = 5;
   localparam int FLG_CAL = 2;
   localparam int FLG_W = 1;
   // Other fields
   localparam int CAL_OFF = 7;
   localparam int CAL_SIGN = 5;
   localparam int WD_KICK = 7;
   localparam int WD_LOCK = 6;
   localparam int IE_WIE = 7;
   localparam int IE_AIE = 6;
   localparam int ALM_MASK = 7;
   // Timing: 100 MHz system clock
   localparam int CLK_HZ = 100_000_000;
   localparam int OSC_HZ = 32768;
   localparam int FAIL_WIN_MS = 5;
   localparam int FAIL_WIN_CYC = CLK_HZ / 1000 * FAIL_WIN_MS;
   localparam int START_MAX_S = 2;
   localparam int START_MAX_CYC = CLK_HZ * START_MAX_S;
   localparam int SEC_CNT = 32768;
   localparam int CAL_SHORT = 128;
   localparam int CAL_LONG = 256;
   localparam int WDOG_DIV = 1024;
   localparam int TEST_DIV = 32;
   localparam int CAL_MINUTES = 64;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [7:0] ONE_BCD = 8'h01;
   localparam logic [7:0] SEC_LAST = 8'h3B;
   localparam logic [7:0] HOUR_LAST = 8'h17;
   localparam logic [2:0] SH_ALM = 3'h4;
endpackage : rtc_pkg

/* rtl/rtc_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
// Small memory holding base time and alarm shadow words, registered read
module rtc_regfile (
   // Clock
   input wire logic i_ref_clk,
   // Write port
   input wire logic i_we,
   input wire logic [2:0] i_waddr,
   input wire logic [7:0] i_wdata,
   // Read port
   input wire logic [2:0] i_raddr,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:7];
   // Store and registered read
   always_ff @(posedge i_ref_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule : rtc_regfile
`default_nettype wire

/* tb/rtc_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the timekeeping core
module rtc_core_monitor (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Inputs
   input wire logic i_supply_ok,
   input wire logic i_cs,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [16:0] i_addr,
   input wire logic [7:0] i_wdata,
   // Outputs
   input wire logic [7:0] o_rdata,
   input wire logic o_irq,
   input wire logic o_osc_enable,
   input wire logic o_on_backup,
   input wire logic o_store_start
);
   import rtc_pkg::*;
   logic w_bit;
   logic next_w_bit;
   logic wr_ok;
   logic rd_ok;
   logic cal_wr;
   // Accepted strobes
   assign wr_ok = i_cs && i_wr && !o_on_backup;
   assign rd_ok = i_cs && i_rd && !o_on_backup;
   assign cal_wr = wr_ok && i_addr == ADDR_CAL;
   // Shadow of the write-enable bit
   always_comb begin
      next_w_bit = w_bit;
      if (wr_ok && i_addr == ADDR_FLAGS) begin
         next_w_bit = i_wdata[FLG_W];
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         w_bit <= 1'b0;
      end else begin
         w_bit <= next_w_bit;
      end
   end
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_flags_rd;
      rd_ok && i_addr == ADDR_FLAGS;
   endsequence
   sequence s_test_off;
      !o_rdata[FLG_CAL];
   endsequence
   property p_irq_clear;
      s_flags_rd ##1 s_test_off |-> !o_irq;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq after flags read");
   property p_w_read;
      s_flags_rd |=> o_rdata[FLG_W] == w_bit;
   endproperty
   a_w_read: assert property (p_w_read) else $error("write bit readback");
   property p_osc_stop;
      cal_wr && i_wdata[CAL_OFF] |=> !o_osc_enable;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped");
   property p_osc_run;
      cal_wr && !i_wdata[CAL_OFF] |=> o_osc_enable;
   endproperty
   a_osc_run: assert property (p_osc_run) else $error("oscillator not running");
   property p_osc_hold;
      !cal_wr |=> $stable(o_osc_enable);
   endproperty
   a_osc_hold: assert property (p_osc_hold) else $error("oscillator bit changed");
   property p_osc_reset;
      $fell(i_sys_rst) |-> o_osc_enable;
   endproperty
   a_osc_reset: assert property (p_osc_reset) else $error("oscillator off at reset");
   property p_rdata_hold;
      !rd_ok |=> $stable(o_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_backup_supply;
      !i_supply_ok [*5] |-> o_on_backup;
   endproperty
   a_backup_supply: assert property (p_backup_supply) else $error("no backup");
   property p_store_backup;
      o_store_start |-> ##[0:3] o_on_backup;
   endproperty
   a_store_backup: assert property (p_store_backup) else $error("store without drop");
endmodule : rtc_core_monitor
bind rtc_core rtc_core_monitor rtc_core_monitor_i (.i_ref_clk(i_ref_clk),
   .i_sys_rst(i_sys_rst), .i_supply_ok(i_supply_ok), .i_cs(i_cs), .i_wr(i_wr),
   .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq),
   .o_osc_enable(o_osc_enable), .o_on_backup(o_on_backup), .o_store_start(o_store_start));
`default_nettype wire

/* tb/rtc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host controller on the byte bus, single-cycle strobes
module rtc_host_model (
   // Clock
   input wire logic i_ref_clk,
   // Bus
   output logic o_cs,
   output logic o_wr,
   output logic o_rd,
   output logic [16:0] o_addr,
   output logic [7:0] o_wdata
);
   // Idle bus at time zero
   initial begin
      o_cs = 1'b0;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 17'h00000;
      o_wdata = 8'h00;
   end
   // One strobe cycle, then scrambled lines so stale values never match
   task automatic xfer(input logic [16:0] a, input logic [7:0] d, input logic w);
      @(posedge i_ref_clk);
      o_cs <= 1'b1;
      o_wr <= w;
      o_rd <= ~w;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_ref_clk);
      o_cs <= 1'b0;
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : xfer
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      xfer(a, d, 1'b1);
   endtask : wr
   task automatic rd(input logic [16:0] a);
      xfer(a, 8'h00, 1'b0);
   endtask : rd
endmodule : rtc_host_model
`default_nettype wire

/* tb/test_rtc_osc_cal_alarm_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
module test_rtc_osc_cal_alarm_watchdog;
   import rtc_pkg::*;
   logic i_ref_clk, i_sys_rst, i_osc_tick, i_supply_ok, i_cs, i_wr, i_rd, rd_pend;
   logic o_irq, o_osc_enable, o_on_backup, o_store_start;
   logic [16:0] i_addr;
   logic [7:0] i_wdata, o_rdata;
   logic [7:0] t [4];
   logic [15:0] exp_q [$];
   logic [31:0] lfsr;
   logic [2:0] div;
   int error_cnt, n_compared, cyc, k, j, n;
   rtc_core rtc_core_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_osc_tick(i_osc_tick),
      .i_supply_ok(i_supply_ok), .i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq), .o_osc_enable(o_osc_enable),
      .o_on_backup(o_on_backup), .o_store_start(o_store_start));
   rtc_host_model rtc_host_model_i (.i_ref_clk(i_ref_clk), .o_cs(i_cs), .o_wr(i_wr),
      .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
   always #5 i_ref_clk = ~i_ref_clk;
   // Oscillator stand-in, eight-cycle period, silent while stopped
   always @(posedge i_ref_clk) begin
      div <= div + 3'h1;
      i_osc_tick <= (o_osc_enable === 1'b1) & div[2];
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_rd(input logic [15:0] e, input logic [7:0] g);
      n_compared++;
      if ((g & e[15:8]) !== (e[7:0] & e[15:8])) begin
         error_cnt++;
         $display("[FAIL] rdata expected %h seen %h", e[7:0], g);
      end
   endtask : chk_rd
   // Note the expected byte, then read
   task automatic rd_exp(input logic [16:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back({m, e});
      rtc_host_model_i.rd(a);
   endtask : rd_exp
   task automatic settle(input int c);
      repeat (c) @(negedge i_ref_clk);
   endtask : settle
   // Cycles between two irq changes
   task automatic meas(output int c);
      logic l;
      for (int p = 0; p < 2; p++) begin
         c = 0;
         l = o_irq;
         while (o_irq === l && c < 600) begin
            settle(1);
            c++;
         end
      end
   endtask : meas
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // Read results taken off the queue as they appear
   always @(posedge i_ref_clk) rd_pend <= i_cs & i_rd & ~o_on_backup;
   always @(negedge i_ref_clk) begin
      if (rd_pend === 1'b1) begin
         if (exp_q.size() == 0) chk("unexpected read", 16'h0000, 16'h0001);
         else chk_rd(exp_q.pop_front(), o_rdata);
      end
   end
   // Hang guard
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         chk("timeout", 16'h0000, 16'h0001);
         stop_test();
      end
   end
   initial begin
      i_ref_clk = 1'b0;
      i_sys_rst = 1'b1;
      i_supply_ok = 1'b0;
      i_osc_tick = 1'b0;
      div = 3'h0;
      rd_pend = 1'b0;
      lfsr = 32'h1F5ED9F6;
      repeat (12) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      i_supply_ok <= 1'b1;
      settle(10);
      chk("osc_enable", 1, o_osc_enable);
      rd_exp(ADDR_FLAGS, 8'h00, 8'hE6);
      $display("test reset done");
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h06);
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h04);
      meas(n);
      chk("test period", 256, 16'(n));
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h06);
      rtc_host_model_i.wr(ADDR_CAL, 8'h3F);
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h04);
      meas(n);
      chk("test period cal", 256, 16'(n));
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h02);
      rtc_host_model_i.wr(ADDR_CAL, 8'hBF);
      settle(2);
      chk("osc stopped", 0, o_osc_enable);
      rtc_host_model_i.wr(ADDR_CAL, 8'h3F);
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h00);
      settle(2);
      chk("osc running", 1, (o_irq !== 1'b0) ? 16'hFFFF : {15'h0000, o_osc_enable});
      $display("test calibration done");
      // Match, date mismatch, date masked
      for (k = 0; k < 3; k++) begin
         lfsr = lfsr_next(lfsr);
         t[0] = 8'(lfsr[7:0] % 60);
         t[1] = 8'(lfsr[15:8] % 60);
         t[2] = 8'(lfsr[23:16] % 24);
         t[3] = 8'(lfsr[31:24] % 28 + 1);
         rtc_host_model_i.wr(ADDR_FLAGS, 8'h02);
         for (j = 0; j < 4; j++) rtc_host_model_i.wr(17'(ADDR_SEC + j), t[j]);
         for (j = 0; j < 3; j++) rtc_host_model_i.wr(17'(ADDR_ALM_SEC + j), t[j]);
         rtc_host_model_i.wr(ADDR_ALM_DATE, {k == 2, 7'(t[3] + (k > 0))});
         rtc_host_model_i.wr(ADDR_IRQ_EN, 8'h40);
         rtc_host_model_i.wr(ADDR_FLAGS, 8'h00);
         settle(30);
         chk("alarm irq", 16'(k != 1), o_irq);
         rd_exp(ADDR_FLAGS, (k != 1) ? 8'h40 : 8'h00, 8'hC0);
         settle(2);
         chk("irq cleared", 0, o_irq);
      end
      $display("test alarm done");
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h02);
      rtc_host_model_i.wr(ADDR_IRQ_EN, 8'h80);
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h00);
      rtc_host_model_i.wr(ADDR_WDOG, 8'h81);
      settle(20000);
      chk("watchdog irq", 1, o_irq);
      rd_exp(ADDR_FLAGS, 8'h80, 8'h80);
      rtc_host_model_i.wr(ADDR_WDOG, 8'hC0);
      settle(20000);
      rd_exp(ADDR_FLAGS, 8'h80, 8'h80);
      rtc_host_model_i.wr(ADDR_WDOG, 8'h80);
      rd_exp(ADDR_FLAGS, 8'h00, 8'h80);
      settle(20000);
      chk("watchdog off", 0, o_irq);
      rd_exp(ADDR_FLAGS, 8'h00, 8'h80);
      $display("test watchdog done");
      @(posedge i_ref_clk);
      i_supply_ok <= 1'b0;
      n = 0;
      while (o_store_start !== 1'b1 && n < 20) begin
         settle(1);
         n++;
      end
      chk("store start", 1, o_store_start);
      settle(4);
      chk("on backup", 1, o_on_backup);
      rtc_host_model_i.rd(ADDR_FLAGS);
      rtc_host_model_i.wr(ADDR_FLAGS, 8'h02);
      @(posedge i_ref_clk);
      i_supply_ok <= 1'b1;
      settle(10);
      chk("backup left", 0, o_on_backup);
      rd_exp(ADDR_FLAGS, 8'h00, 8'h02);
      $display("test backup done");
      stop_test();
   end
endmodule : test_rtc_osc_cal_alarm_watchdog
`default_nettype wire
